// file: hw/ecpwm_pkg.sv
// constants for the eight channel pwm timer: register map, reset values,
// bus response codes and field widths.
// assumes a 32-bit axi4-lite register bus with word aligned registers.
package ecpwm_pkg;
    localparam int          NUM_CH        = 8;
    localparam int          NUM_PAIR      = 4;
    localparam int          CH_W          = 8;
    localparam int          WIDE_W        = 16;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;

    localparam logic [7:0]  OFS_ENABLE    = 8'h00;
    localparam logic [7:0]  OFS_POLARITY  = 8'h04;
    localparam logic [7:0]  OFS_CENTER    = 8'h08;
    localparam logic [7:0]  OFS_CONCAT    = 8'h0C;
    localparam logic [7:0]  OFS_PCM       = 8'h10;
    localparam logic [7:0]  OFS_PERIOD    = 8'h20;
    localparam logic [7:0]  OFS_DUTY      = 8'h40;
    localparam logic [7:0]  OFS_COUNT     = 8'h60;
    localparam logic [7:0]  BANK_MASK     = 8'hE0;

    localparam logic [7:0]  RST_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_POLARITY  = 8'hFF;
    localparam logic [7:0]  RST_CENTER    = 8'h00;
    localparam logic [3:0]  RST_CONCAT    = 4'h0;
    localparam logic [7:0]  RST_PCM       = 8'h00;
    localparam logic [7:0]  RST_PERIOD    = 8'hFF;
    localparam logic [7:0]  RST_DUTY      = 8'h00;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// file: hw/ecpwm_top.sv
// eight channel pwm timer with axi4-lite register access.
// assumes one 40 mhz clock, synchronous active low reset, and pins driven
// straight from the pwm output flip-flops.
`timescale 1ns/1ps

// Operation
// (R01) eight channels, each with own 8-bit counter, period and duty
// (R02) each channel runs continuously and independently once enabled
// (R03) duty zero never active; duty at or above period always active; the code lets the second win, so duty zero with period zero is active
// (R04) pcm mode spreads active cycles over the period by accumulation
// (R05) per channel polarity bit selects whether duty drives high or low
// (R06) per channel choice of left or centre aligned pulse
// (R07) pairs 7:6, 5:4, 3:2, 1:0 join into one 16-bit channel
// (R08) concatenation chosen per pair, any mix of 8-bit and 16-bit
// (R09) left counts up and wraps; centre counts up then back down
module ecpwm_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [7:0]                 pwm_out
);
    logic [7:0]  enable_reg;
    logic [7:0]  polarity_reg;
    logic [7:0]  center_reg;
    logic [3:0]  concat_reg;
    logic [7:0]  pcm_reg;
    logic [7:0]  period_reg [0:7];
    logic [7:0]  duty_reg   [0:7];
    logic [7:0]  cnt_reg    [0:7];
    logic [7:0]  pwm_out_reg;

    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    logic        do_write;
    logic        wr_hit;
    logic [2:0]  wr_idx;
    logic [7:0]  wr_byte;
    logic [31:0] rd_next;
    logic        rd_hit;

    // one counting step: returns {dir, active, count}
    function automatic logic [17:0] pwm_step(
        input logic [15:0] cnt,
        input logic        dir,
        input logic [15:0] per,
        input logic [15:0] duty,
        input logic        center,
        input logic        pcm
    );
        logic [16:0] sum;
        logic [15:0] c;
        logic        d;
        logic        a;
        begin
            sum = {1'b0, cnt} + {1'b0, duty};
            c = cnt;
            d = dir;
            a = (cnt < duty) || (duty >= per);                 // (R03)
            if (pcm) begin
                d = 1'b0;
                if (duty >= per) begin
                    a = 1'b1;                                  // (R03)
                end else if (sum >= {1'b0, per}) begin
                    a = 1'b1;                                  // (R04)
                    c = 16'(sum - {1'b0, per});
                end else begin
                    a = 1'b0;
                    c = sum[15:0];
                end
            end else if (center) begin                         // (R06)
                if (!dir) begin
                    if (cnt >= per) begin
                        d = 1'b1;                              // (R09)
                        c = (per == 16'h0000) ? 16'h0000 : cnt - 16'h0001;
                    end else begin
                        c = cnt + 16'h0001;
                    end
                end else begin
                    if (cnt == 16'h0000) begin
                        d = 1'b0;                              // (R09)
                        c = (per == 16'h0000) ? 16'h0000 : 16'h0001;
                    end else begin
                        c = cnt - 16'h0001;
                    end
                end
            end else begin
                d = 1'b0;
                if ({1'b0, cnt} + 17'h00001 >= {1'b0, per}) begin
                    c = 16'h0000;                              // (R09)
                end else begin
                    c = cnt + 16'h0001;
                end
            end
            pwm_step = {d, a, c};
        end
    endfunction

    // per pair counters, 8-bit or joined 16-bit
    genvar k;
    generate
        for (k = 0; k < ecpwm_pkg::NUM_PAIR; k++) begin : g_pair
            localparam int LO = 2 * k;
            localparam int HI = 2 * k + 1;
            logic [1:0]  dir_reg;
            logic [17:0] st_lo;
            logic [17:0] st_hi;
            logic [17:0] st_cat;
            logic        join_pair;

            assign join_pair = concat_reg[k];
            assign st_lo = pwm_step({8'h00, cnt_reg[LO]}, dir_reg[0],
                {8'h00, period_reg[LO]}, {8'h00, duty_reg[LO]},
                center_reg[LO], pcm_reg[LO]);                  // (R01)
            assign st_hi = pwm_step({8'h00, cnt_reg[HI]}, dir_reg[1],
                {8'h00, period_reg[HI]}, {8'h00, duty_reg[HI]},
                center_reg[HI], pcm_reg[HI]);                  // (R01)
            assign st_cat = pwm_step({cnt_reg[HI], cnt_reg[LO]}, dir_reg[1],
                {period_reg[HI], period_reg[LO]},
                {duty_reg[HI], duty_reg[LO]},
                center_reg[HI], pcm_reg[HI]);                  // (R07)

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_reg[LO] <= 8'h00;
                    cnt_reg[HI] <= 8'h00;
                    dir_reg     <= 2'h0;
                    pwm_out_reg[LO] <= 1'b0;
                    pwm_out_reg[HI] <= 1'b0;
                end else if (join_pair) begin                  // (R08)
                    // joined pair: odd channel settings and pin rule
                    pwm_out_reg[LO] <= ~polarity_reg[LO];
                    dir_reg[0]      <= 1'b0;
                    if (enable_reg[HI]) begin
                        {cnt_reg[HI], cnt_reg[LO]} <= st_cat[15:0]; // (R07)
                        dir_reg[1]      <= st_cat[17];
                        pwm_out_reg[HI] <= st_cat[16] ~^ polarity_reg[HI]; // (R05)
                    end else begin
                        cnt_reg[LO]     <= 8'h00;
                        cnt_reg[HI]     <= 8'h00;
                        dir_reg[1]      <= 1'b0;
                        pwm_out_reg[HI] <= ~polarity_reg[HI];
                    end
                end else begin
                    if (enable_reg[LO]) begin                  // (R02)
                        cnt_reg[LO]     <= st_lo[7:0];
                        dir_reg[0]      <= st_lo[17];
                        pwm_out_reg[LO] <= st_lo[16] ~^ polarity_reg[LO]; // (R05)
                    end else begin
                        cnt_reg[LO]     <= 8'h00;
                        dir_reg[0]      <= 1'b0;
                        pwm_out_reg[LO] <= ~polarity_reg[LO];
                    end
                    if (enable_reg[HI]) begin                  // (R02)
                        cnt_reg[HI]     <= st_hi[7:0];
                        dir_reg[1]      <= st_hi[17];
                        pwm_out_reg[HI] <= st_hi[16] ~^ polarity_reg[HI]; // (R05)
                    end else begin
                        cnt_reg[HI]     <= 8'h00;
                        dir_reg[1]      <= 1'b0;
                        pwm_out_reg[HI] <= ~polarity_reg[HI];
                    end
                end
            end
        end
    endgenerate

    assign pwm_out = pwm_out_reg;

    // write channel: address and data taken in either order
    assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_idx   = aw_addr_reg[4:2];
    assign wr_byte  = w_data_reg[7:0];
    assign wr_hit   = (aw_addr_reg[1:0] == 2'h0) &&
        ((aw_addr_reg == ecpwm_pkg::OFS_ENABLE) ||
         (aw_addr_reg == ecpwm_pkg::OFS_POLARITY) ||
         (aw_addr_reg == ecpwm_pkg::OFS_CENTER) ||
         (aw_addr_reg == ecpwm_pkg::OFS_CONCAT) ||
         (aw_addr_reg == ecpwm_pkg::OFS_PCM) ||
         ((aw_addr_reg & ecpwm_pkg::BANK_MASK) == ecpwm_pkg::OFS_PERIOD) ||
         ((aw_addr_reg & ecpwm_pkg::BANK_MASK) == ecpwm_pkg::OFS_DUTY));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= ecpwm_pkg::RESP_OKAY;
        end else begin
            awready_reg <= !aw_got_reg && !(s_axi_awvalid && awready_reg);
            wready_reg  <= !w_got_reg && !(s_axi_wvalid && wready_reg);
            if (s_axi_awvalid && awready_reg) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? ecpwm_pkg::RESP_OKAY
                                     : ecpwm_pkg::RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg  <= 1'b0;
                aw_got_reg  <= 1'b0;
                w_got_reg   <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_reg   <= ecpwm_pkg::RST_ENABLE;
            polarity_reg <= ecpwm_pkg::RST_POLARITY;
            center_reg   <= ecpwm_pkg::RST_CENTER;
            concat_reg   <= ecpwm_pkg::RST_CONCAT;
            pcm_reg      <= ecpwm_pkg::RST_PCM;
            for (int i = 0; i < ecpwm_pkg::NUM_CH; i++) begin
                period_reg[i] <= ecpwm_pkg::RST_PERIOD;
                duty_reg[i]   <= ecpwm_pkg::RST_DUTY;
            end
        end else if (do_write && wr_hit && w_strb_reg[0]) begin
            if (aw_addr_reg == ecpwm_pkg::OFS_ENABLE) begin
                enable_reg <= wr_byte;                         // (R02)
            end
            if (aw_addr_reg == ecpwm_pkg::OFS_POLARITY) begin
                polarity_reg <= wr_byte;                       // (R05)
            end
            if (aw_addr_reg == ecpwm_pkg::OFS_CENTER) begin
                center_reg <= wr_byte;                         // (R06)
            end
            if (aw_addr_reg == ecpwm_pkg::OFS_CONCAT) begin
                concat_reg <= wr_byte[3:0];                    // (R08)
            end
            if (aw_addr_reg == ecpwm_pkg::OFS_PCM) begin
                pcm_reg <= wr_byte;                            // (R04)
            end
            if ((aw_addr_reg & ecpwm_pkg::BANK_MASK) ==
                ecpwm_pkg::OFS_PERIOD) begin
                period_reg[wr_idx] <= wr_byte;                 // (R01)
            end
            if ((aw_addr_reg & ecpwm_pkg::BANK_MASK) ==
                ecpwm_pkg::OFS_DUTY) begin
                duty_reg[wr_idx] <= wr_byte;                   // (R01)
            end
        end
    end

    // read decode
    always_comb begin
        rd_next = 32'h00000000;
        rd_hit  = (s_axi_araddr[1:0] == 2'h0);
        if (s_axi_araddr == ecpwm_pkg::OFS_ENABLE) begin
            rd_next[7:0] = enable_reg;
        end else if (s_axi_araddr == ecpwm_pkg::OFS_POLARITY) begin
            rd_next[7:0] = polarity_reg;
        end else if (s_axi_araddr == ecpwm_pkg::OFS_CENTER) begin
            rd_next[7:0] = center_reg;
        end else if (s_axi_araddr == ecpwm_pkg::OFS_CONCAT) begin
            rd_next[3:0] = concat_reg;
        end else if (s_axi_araddr == ecpwm_pkg::OFS_PCM) begin
            rd_next[7:0] = pcm_reg;
        end else if ((s_axi_araddr & ecpwm_pkg::BANK_MASK) ==
                     ecpwm_pkg::OFS_PERIOD) begin
            rd_next[7:0] = period_reg[s_axi_araddr[4:2]];
        end else if ((s_axi_araddr & ecpwm_pkg::BANK_MASK) ==
                     ecpwm_pkg::OFS_DUTY) begin
            rd_next[7:0] = duty_reg[s_axi_araddr[4:2]];
        end else if ((s_axi_araddr & ecpwm_pkg::BANK_MASK) ==
                     ecpwm_pkg::OFS_COUNT) begin
            rd_next[7:0] = cnt_reg[s_axi_araddr[4:2]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= ecpwm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_hit ? rd_next : 32'h00000000;
            rresp_reg   <= rd_hit ? ecpwm_pkg::RESP_OKAY
                                  : ecpwm_pkg::RESP_SLVERR;
        end else if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end else begin
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule

// file: testbench/ecpwm_checker.sv
// checker for the pwm timer: register bus handshakes and pin reset level.
// assumes it is bound onto ecpwm_top and sees only its ports.
`timescale 1ns/1ps
module ecpwm_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  pwm_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped early");
    AST_WR_BLOCK: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |->
        ##[1:2] s_axi_rvalid) else $error("read response missing");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response changed early");
    AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    AST_BYTE_WIDE: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    AST_ERR_ZERO: assert property (s_axi_rvalid &&
        s_axi_rresp == ecpwm_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    AST_PIN_REL: assert property (
        $rose(aresetn) |-> pwm_out == 8'h00)
        else $error("pins not idle after reset");
endmodule

bind ecpwm_top ecpwm_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_out(pwm_out));

// file: testbench/ecpwm_load.sv
// load on the pwm pins: counts high samples and rising edges per pin.
// assumes pins are sampled on the rising clock edge; clr zeroes counts.
`timescale 1ns/1ps
module ecpwm_load (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic [7:0]       pins,
    output logic      [7:0][15:0] hi,
    output logic      [7:0][15:0] rs
);
    logic [7:0] prev;

    always_ff @(posedge clk) begin
        prev <= pins;
        for (int i = 0; i < 8; i++) begin
            if (clr) begin
                hi[i] <= 16'h0000;
                rs[i] <= 16'h0000;
            end else begin
                hi[i] <= hi[i] + 16'(pins[i]);
                rs[i] <= rs[i] + 16'(pins[i] & ~prev[i]);
            end
        end
    end
endmodule

// file: testbench/tb.sv
// bench for the pwm timer: register access over axi4-lite and pin waves.
// assumes package, top, load model and bound checker are compiled first.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0]  PER [8] = '{8'h0A, 8'h08, 8'h05, 8'h0A,
                                        8'h05, 8'h0A, 8'h2C, 8'h01};
    localparam logic [7:0]  DTY [8] = '{8'h03, 8'h00, 8'h05, 8'h03,
                                        8'h02, 8'h03, 8'h96, 8'h00};
    localparam logic [15:0] HIGH [8] = '{16'hB4, 16'h0, 16'h258, 16'h1A4,
                                         16'hB4, 16'hB4, 16'h0, 16'h12C};
    logic             aclk, aresetn, awvalid, awready, wvalid, wready;
    logic             bvalid, bready, arvalid, arready, rvalid, rready, clr;
    logic [7:0]       awaddr, araddr, pwm_out;
    logic [1:0]       bresp, rresp, resp;
    logic [31:0]      wdata, rdata, rd_data;
    logic [7:0][15:0] hi, rs;
    int               miscompares, samples_checked;

    ecpwm_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_out(pwm_out));
    ecpwm_load u_load (.clk(aclk), .clr(clr), .pins(pwm_out), .hi(hi),
        .rs(rs));

    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 100) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        resp = bresp;
        tmo((bvalid === 1'b1) ? 0 : 100);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready  <= 1'b0;
        rd_data = rdata;
        resp    = rresp;
        tmo((rvalid === 1'b1) ? 0 : 100);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
        rd(a);
        chk(rd_data, d);
        chk(32'(resp), 32'(r));
    endtask
    task automatic window(input int n);
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic t_regs();
        rchk(ecpwm_pkg::OFS_POLARITY, 32'hFF, ecpwm_pkg::RESP_OKAY);
        rchk(ecpwm_pkg::OFS_PERIOD + 8'h1C, 32'hFF, 2'h0);
        rchk(ecpwm_pkg::OFS_DUTY, 32'h0, ecpwm_pkg::RESP_OKAY);
        rchk(ecpwm_pkg::OFS_CENTER, 32'h0, ecpwm_pkg::RESP_OKAY);
        rchk(ecpwm_pkg::OFS_CONCAT, 32'h0, ecpwm_pkg::RESP_OKAY);
        rchk(ecpwm_pkg::OFS_PCM, 32'h0, ecpwm_pkg::RESP_OKAY);
        rchk(ecpwm_pkg::OFS_COUNT, 32'h0, ecpwm_pkg::RESP_OKAY);
        rchk(8'h80, 32'h0, ecpwm_pkg::RESP_SLVERR);
        wr(ecpwm_pkg::OFS_COUNT, 32'h55);
        chk(32'(resp), 32'(ecpwm_pkg::RESP_SLVERR));
        wr(ecpwm_pkg::OFS_PERIOD + 8'h0C, 32'hFFFFFF5A);
        chk(32'(resp), 32'(ecpwm_pkg::RESP_OKAY));
        rchk(ecpwm_pkg::OFS_PERIOD + 8'h0C, 32'h5A, 2'h0);
    endtask
    task automatic t_wave();
        for (int i = 0; i < 8; i++) begin
            wr(ecpwm_pkg::OFS_PERIOD + 8'(4 * i), 32'(PER[i]));
            wr(ecpwm_pkg::OFS_DUTY + 8'(4 * i), 32'(DTY[i]));
        end
        wr(ecpwm_pkg::OFS_POLARITY, 32'hF7);
        wr(ecpwm_pkg::OFS_CENTER, 32'h10);
        wr(ecpwm_pkg::OFS_PCM, 32'h20);
        wr(ecpwm_pkg::OFS_CONCAT, 32'h08);
        wr(ecpwm_pkg::OFS_ENABLE, 32'hFF);
        repeat (10) @(posedge aclk);
        window(600);
        for (int i = 0; i < 8; i++) begin
            chk(32'(hi[i]), 32'(HIGH[i]));
        end
        chk(32'(rs[0]), 32'h3C);
        chk(32'(rs[4]), 32'h3C);
        chk(32'(rs[5]), 32'hB4);
        chk(32'(rs[7]), 32'h2);
        chk(32'(hi[6]), 32'h0);
    endtask
    task automatic t_off();
        wr(ecpwm_pkg::OFS_ENABLE, 32'h00);
        repeat (4) @(posedge aclk);
        window(100);
        for (int i = 0; i < 8; i++) begin
            chk(32'(hi[i]), (i == 3) ? 32'h64 : 32'h0);
        end
        wr(ecpwm_pkg::OFS_CONCAT, 32'h00);
        wr(ecpwm_pkg::OFS_ENABLE, 32'hC0);
        repeat (4) @(posedge aclk);
        window(100);
        chk(32'(hi[6]), 32'h64);
        chk(32'(hi[7]), 32'h0);
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        miscompares = 0;
        samples_checked = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_wave();
        t_off();
        end_sim();
    end
endmodule
